// [hw/nsx_pkg.sv]
package nsx_pkg;

   // Opcode patterns (13-bit)
   localparam logic [12:0] OP_SHL_MEM    = 13'h10E0;  // 10E0..10E3
   localparam logic [12:0] OP_SHR_MEM    = 13'h10E4;  // 10E4..10E7
   localparam logic [12:0] OP_SHR_REG_1  = 13'h10F1;
   localparam logic [12:0] OP_SHR_REG_2  = 13'h10F5;
   localparam logic [12:0] OP_SLEEP      = 13'h1FFD;
   localparam logic [12:0] OP_SUB_RR     = 13'h1870;  // 1870..1877
   localparam logic [12:0] OP_SUB_RI     = 13'h1840;  // 1840..185F
   localparam logic [12:0] OP_SUB_RM     = 13'h1860;  // 1860..1867
   localparam logic [12:0] OP_SUB_MR     = 13'h1868;  // 1868..186F
   localparam logic [12:0] OP_SUB_MI     = 13'h1800;  // 1800..183F

   // Page bases used with the page offset extension
   localparam logic [15:0] PAGE_BASE_1   = 16'h0000;
   localparam logic [15:0] PAGE_BASE_2   = 16'hFF00;

   // Reset values
   localparam logic [15:0] PTR_RST       = 16'h0000;
   localparam logic [3:0]  NIB_RST       = 4'h0;

   // Decoded operation classes
   typedef enum logic [3:0] {
      NSX_NONE, NSX_SHL_M, NSX_SHR_M, NSX_SHR_R, NSX_SUB_RR, NSX_SUB_RI,
      NSX_SUB_RM, NSX_SUB_MR, NSX_SUB_MI, NSX_SLEEP
   } nsx_op_t;

   // Decoded instruction
   typedef struct packed {
      nsx_op_t    op;        // Operation class
      logic       ptr_sel;   // 0 pointer_1, 1 pointer_2
      logic       post_inc;  // Pointer post-increment
      logic       dst_sel;   // Destination register select
      logic       src_sel;   // Source register select
      logic [3:0] imm;       // Immediate nibble
      logic       two_cyc;   // Takes two cycles
   } nsx_dec_t;

   // Data memory request
   typedef struct packed {
      logic        rd;       // Read strobe
      logic        wr;       // Write strobe
      logic [15:0] addr;     // Nibble address
      logic [3:0]  wdata;    // Write data
   } nsx_mem_req_t;

endpackage

// [hw/nsx_decode.sv]
`timescale 1ns/1ps
// Combinational opcode decoder
module nsx_decode (
   input  wire logic [12:0]       opcode_i, // Instruction word
   output nsx_pkg::nsx_dec_t      dec_o     // Decoded fields
);

   // Classify the opcode by its fixed bits
   always_comb begin
      dec_o          = '0;
      dec_o.op       = nsx_pkg::NSX_NONE;
      dec_o.ptr_sel  = opcode_i[1];
      dec_o.post_inc = opcode_i[0];
      dec_o.dst_sel  = opcode_i[2];
      dec_o.src_sel  = opcode_i[1];
      dec_o.imm      = opcode_i[3:0];
      if (opcode_i == nsx_pkg::OP_SLEEP) begin
         dec_o.op      = nsx_pkg::NSX_SLEEP;
         dec_o.two_cyc = 1'b1;
      end else if ((opcode_i == nsx_pkg::OP_SHR_REG_1) || (opcode_i == nsx_pkg::OP_SHR_REG_2)) begin
         dec_o.op       = nsx_pkg::NSX_SHR_R;
         dec_o.dst_sel  = opcode_i[2];
         dec_o.post_inc = 1'b0;
      end else if (opcode_i[12:2] == nsx_pkg::OP_SHL_MEM[12:2]) begin
         dec_o.op      = nsx_pkg::NSX_SHL_M;
         dec_o.two_cyc = opcode_i[0];
      end else if (opcode_i[12:2] == nsx_pkg::OP_SHR_MEM[12:2]) begin
         dec_o.op      = nsx_pkg::NSX_SHR_M;
         dec_o.two_cyc = opcode_i[0];
      end else if (opcode_i[12:3] == nsx_pkg::OP_SUB_RR[12:3]) begin
         dec_o.op       = nsx_pkg::NSX_SUB_RR;
         dec_o.post_inc = 1'b0;
      end else if (opcode_i[12:5] == nsx_pkg::OP_SUB_RI[12:5]) begin
         dec_o.op       = nsx_pkg::NSX_SUB_RI;
         dec_o.dst_sel  = opcode_i[4];
         dec_o.post_inc = 1'b0;
      end else if (opcode_i[12:3] == nsx_pkg::OP_SUB_RM[12:3]) begin
         dec_o.op = nsx_pkg::NSX_SUB_RM;
      end else if (opcode_i[12:3] == nsx_pkg::OP_SUB_MR[12:3]) begin
         dec_o.op      = nsx_pkg::NSX_SUB_MR;
         dec_o.two_cyc = 1'b1;
      end else if (opcode_i[12:6] == nsx_pkg::OP_SUB_MI[12:6]) begin
         dec_o.op       = nsx_pkg::NSX_SUB_MI;
         dec_o.ptr_sel  = opcode_i[5];
         dec_o.post_inc = opcode_i[4];
         dec_o.two_cyc  = 1'b1;
      end
   end

endmodule

// [hw/nsx_alu.sv]
`timescale 1ns/1ps
// Nibble shift and subtract unit
module nsx_alu (
   input  wire logic              shl_i,    // Shift left
   input  wire logic              shr_i,    // Shift right
   input  wire logic [3:0]        a_i,      // Minuend or shift operand
   input  wire logic [3:0]        b_i,      // Subtrahend
   output logic      [3:0]        res_o,    // Result
   output logic                   carry_o,  // Carry or borrow
   output logic                   zero_o    // Result is zero
);

   logic [4:0] diff;

   // Borrow out of bit 3 from a 5-bit difference
   assign diff = {1'b0, a_i} - {1'b0, b_i};

   // Select shift or subtract result
   always_comb begin
      if (shl_i) begin
         res_o   = {a_i[2:0], 1'b0};
         carry_o = a_i[3];
      end else if (shr_i) begin
         res_o   = {1'b0, a_i[3:1]};
         carry_o = a_i[0];
      end else begin
         res_o   = diff[3:0];
         carry_o = diff[4];
      end
      zero_o = (res_o == 4'h0);
   end

endmodule

// [hw/nsx_exec.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - 10E0/10E2 shift memory left, bit3 to carry
// - 10E1/10E3 also increment pointer, two cycles
// - Pointer increments never touch the flags
// - Page offset gives 0000H or FF00H page
// - Post-increment and register forms ignore page offset
// - 1FFD sleeps in two cycles, stopping all
// - External interrupt wakes core from sleep
// - 10F1/10F5 shift register right, one cycle
// - 10E4/10E6 shift memory right, bit0 to carry
// - 10E5/10E7 also increment pointer, two cycles
// - 1870-1877 register minus register, one cycle
// - 1840-185F register minus immediate, one cycle
// - 1860-1866 even: register minus memory, page ok
// - Odd 1861-1867 also increment pointer, one cycle
// - 1868-186E even: memory minus register, write back
// - Odd 1869-186F also increment pointer, two cycles
// - 1800-180F/1820-182F memory minus immediate, write back
// - Post-increment immediate form increments pointer, two cycles
// - 1810-181F/1830-183F decode immediate post-increment form
//
// Timing: an instruction is presented with instr_valid_i while instr_ready_o
// is high. One-cycle ops complete in the same cycle (memory read data must be
// returned combinationally on mem_rdata_i). Two-cycle ops read in cycle one
// and write or finish in cycle two, holding instr_ready_o low in between.
module nsx_exec (
   input  wire logic                   ref_clk_i,       // Core clock
   input  wire logic                   rst_n_i,         // Async reset, active low
   input  wire logic                   instr_valid_i,   // Opcode present
   input  wire logic [12:0]            opcode_i,        // Opcode word
   input  wire logic                   page_load_i,     // Load of page offset
   input  wire logic [7:0]             page_byte_i,     // Page offset byte
   input  wire logic                   ext_irq_i,       // External interrupt
   input  wire logic [3:0]             mem_rdata_i,     // Memory read data
   output logic                        instr_ready_o,   // Ready for an opcode
   output nsx_pkg::nsx_mem_req_t       mem_req_o,       // Memory request
   output logic [3:0]                  work_reg_1_o,    // Work register 1
   output logic [3:0]                  work_reg_2_o,    // Work register 2
   output logic [15:0]                 pointer_1_o,     // Pointer 1
   output logic [15:0]                 pointer_2_o,     // Pointer 2
   output logic                        carry_o,         // Carry flag
   output logic                        zero_o,          // Zero flag
   output logic                        sleep_o          // Sleep state
);

   typedef enum logic [1:0] {NSX_RUN, NSX_SECOND, NSX_SLEEPING} nsx_state_t;

   nsx_state_t        state_reg;
   nsx_pkg::nsx_dec_t dec_now;
   nsx_pkg::nsx_dec_t dec_reg;
   nsx_pkg::nsx_dec_t dec;
   logic [3:0]        regs_reg [2];
   logic [15:0]       ptr_reg  [2];
   logic [7:0]        page_reg;
   logic              page_valid_reg;
   logic              carry_reg;
   logic              zero_reg;
   logic [3:0]        mem_data_reg;
   logic              first_cyc;
   logic              second_cyc;
   logic              use_page;
   logic [15:0]       addr;
   logic [15:0]       addr_reg;
   logic [3:0]        alu_a;
   logic [3:0]        alu_b;
   logic [3:0]        alu_res;
   logic              alu_c;
   logic              alu_z;
   logic              mem_op;
   logic              write_back;

   nsx_decode u_decode (
      .opcode_i (opcode_i),
      .dec_o    (dec_now)
   );

   // Accept in run state; second cycle works from the held decode
   assign first_cyc     = (state_reg == NSX_RUN) && instr_valid_i;
   assign second_cyc    = (state_reg == NSX_SECOND);
   assign dec           = second_cyc ? dec_reg : dec_now;
   assign instr_ready_o = (state_reg == NSX_RUN);

   // Page offset only for memory forms without post-increment
   assign mem_op   = (dec.op == nsx_pkg::NSX_SHL_M) || (dec.op == nsx_pkg::NSX_SHR_M) ||
                     (dec.op == nsx_pkg::NSX_SUB_RM) || (dec.op == nsx_pkg::NSX_SUB_MR) ||
                     (dec.op == nsx_pkg::NSX_SUB_MI);
   assign use_page = page_valid_reg && mem_op && !dec.post_inc;

   // Operand address: pointer or paged byte
   always_comb begin
      if (second_cyc) begin
         addr = addr_reg;
      end else if (use_page) begin
         addr = (dec.ptr_sel ? nsx_pkg::PAGE_BASE_2 : nsx_pkg::PAGE_BASE_1)
                | {8'h00, page_reg};
      end else begin
         addr = ptr_reg[dec.ptr_sel];
      end
   end

   // ALU operand selection; memory value comes live or from the held read
   always_comb begin
      alu_a = regs_reg[dec.dst_sel];
      alu_b = nsx_pkg::NIB_RST;
      case (dec.op)
         nsx_pkg::NSX_SUB_RR: alu_b = regs_reg[dec.src_sel];
         nsx_pkg::NSX_SUB_RI: alu_b = dec.imm;
         nsx_pkg::NSX_SUB_RM: alu_b = mem_rdata_i;
         nsx_pkg::NSX_SUB_MR: begin
            alu_a = mem_data_reg;
            alu_b = regs_reg[dec.dst_sel];
         end
         nsx_pkg::NSX_SUB_MI: begin
            alu_a = mem_data_reg;
            alu_b = dec.imm;
         end
         nsx_pkg::NSX_SHL_M,
         nsx_pkg::NSX_SHR_M: alu_a = second_cyc ? mem_data_reg : mem_rdata_i;
         default: ;
      endcase
   end

   nsx_alu u_alu (
      .shl_i   (dec.op == nsx_pkg::NSX_SHL_M),
      .shr_i   ((dec.op == nsx_pkg::NSX_SHR_M) || (dec.op == nsx_pkg::NSX_SHR_R)),
      .a_i     (alu_a),
      .b_i     (alu_b),
      .res_o   (alu_res),
      .carry_o (alu_c),
      .zero_o  (alu_z)
   );

   // Write-back happens in the second cycle for two-cycle memory writers,
   // and in the first for single-cycle memory shifts
   assign write_back = (second_cyc && ((dec.op == nsx_pkg::NSX_SUB_MR) ||
                                       (dec.op == nsx_pkg::NSX_SUB_MI) ||
                                       (dec.op == nsx_pkg::NSX_SHL_M) ||
                                       (dec.op == nsx_pkg::NSX_SHR_M))) ||
                       (first_cyc && !dec.two_cyc &&
                        ((dec.op == nsx_pkg::NSX_SHL_M) || (dec.op == nsx_pkg::NSX_SHR_M)));

   // Memory request: read in first cycle, write when results are due
   always_comb begin
      mem_req_o       = '0;
      mem_req_o.addr  = addr;
      mem_req_o.wdata = alu_res;
      mem_req_o.rd    = first_cyc && mem_op;
      mem_req_o.wr    = write_back;
   end

   // Sequencer: second cycle, sleep entry and external wake-up
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= NSX_RUN;
      end else begin
         case (state_reg)
            NSX_RUN:
               if (first_cyc && dec_now.two_cyc) begin
                  state_reg <= NSX_SECOND;
               end
            NSX_SECOND:
               if (dec_reg.op == nsx_pkg::NSX_SLEEP) begin
                  state_reg <= ext_irq_i ? NSX_RUN : NSX_SLEEPING;
               end else begin
                  state_reg <= NSX_RUN;
               end
            NSX_SLEEPING:
               if (ext_irq_i) begin
                  state_reg <= NSX_RUN;
               end
            default: state_reg <= NSX_RUN;
         endcase
      end
   end

   // Hold the decode and memory read across the second cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dec_reg      <= '0;
         mem_data_reg <= nsx_pkg::NIB_RST;
         addr_reg     <= nsx_pkg::PTR_RST;
      end else if (first_cyc) begin
         dec_reg      <= dec_now;
         mem_data_reg <= mem_rdata_i;
         addr_reg     <= addr;  // Paged address must survive the consumed offset
      end
   end

   // Page offset register: armed by a load, consumed by the next instruction
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_reg       <= 8'h00;
         page_valid_reg <= 1'b0;
      end else if (page_load_i) begin
         page_reg       <= page_byte_i;
         page_valid_reg <= 1'b1;
      end else if (first_cyc) begin
         page_valid_reg <= 1'b0;
      end
   end

   // Flags follow only the shift or subtract result
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         carry_reg <= 1'b0;
         zero_reg  <= 1'b0;
      end else if ((first_cyc && !dec.two_cyc && dec.op != nsx_pkg::NSX_NONE) ||
                   (write_back && second_cyc)) begin
         carry_reg <= alu_c;
         zero_reg  <= alu_z;
      end
   end

   // Work registers: register-destination results
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         regs_reg[0] <= nsx_pkg::NIB_RST;
         regs_reg[1] <= nsx_pkg::NIB_RST;
      end else if (first_cyc && ((dec.op == nsx_pkg::NSX_SHR_R) || (dec.op == nsx_pkg::NSX_SUB_RR) ||
                                 (dec.op == nsx_pkg::NSX_SUB_RI) || (dec.op == nsx_pkg::NSX_SUB_RM))) begin
         regs_reg[dec.dst_sel] <= alu_res;
      end
   end

   // Pointers: post-increment after the operand access, flags untouched
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr_reg[0] <= nsx_pkg::PTR_RST;
         ptr_reg[1] <= nsx_pkg::PTR_RST;
      end else if (mem_op && dec.post_inc &&
                   ((second_cyc) || (first_cyc && !dec.two_cyc))) begin
         ptr_reg[dec.ptr_sel] <= ptr_reg[dec.ptr_sel] + 16'h0001;
      end
   end

   assign work_reg_1_o = regs_reg[0];
   assign work_reg_2_o = regs_reg[1];
   assign pointer_1_o  = ptr_reg[0];
   assign pointer_2_o  = ptr_reg[1];
   assign carry_o      = carry_reg;
   assign zero_o       = zero_reg;
   assign sleep_o      = (state_reg == NSX_SLEEPING);

endmodule

// [bench/nsx_mem_model.sv]
`timescale 1ns/1ps
// Nibble data memory on the far side of the executor
module nsx_mem_model (
   input  wire logic                  ref_clk_i,   // Core clock
   input  wire nsx_pkg::nsx_mem_req_t mem_req_i,   // Request from the core
   output logic [3:0]                 mem_rdata_o  // Read data
);
   logic [3:0] mem [0:65535];  // Nibble store, loaded by the bench
   logic [3:0] last_reg = 4'h5; // Last nibble handed out

   // Read answers at once; an idle bus shows the inverse of the last read
   always_comb begin
      if (mem_req_i.rd) begin
         mem_rdata_o = mem[mem_req_i.addr];
      end else begin
         mem_rdata_o = ~last_reg;
      end
   end

   // Writes land on the clock edge
   always @(posedge ref_clk_i) begin
      if (mem_req_i.wr) begin
         mem[mem_req_i.addr] <= mem_req_i.wdata;
      end
      if (mem_req_i.rd) begin
         last_reg <= mem[mem_req_i.addr];
      end
   end
endmodule

// [bench/nsx_exec_monitor.sv]
`timescale 1ns/1ps
// Port-level checker for the executor
module nsx_exec_monitor (
   input wire logic                  ref_clk_i,     // Clock
   input wire logic                  rst_n_i,       // Reset
   input wire logic                  instr_valid_i, // Opcode present
   input wire logic [12:0]           opcode_i,      // Opcode
   input wire logic                  page_load_i,   // Page load
   input wire logic [7:0]            page_byte_i,   // Page byte
   input wire logic                  ext_irq_i,     // Interrupt
   input wire logic [3:0]            mem_rdata_i,   // Read data
   input wire logic                  instr_ready_o, // Ready
   input wire nsx_pkg::nsx_mem_req_t mem_req_o,     // Memory request
   input wire logic [3:0]            work_reg_1_o,  // Register 1
   input wire logic [15:0]           pointer_1_o,   // Pointer 1
   input wire logic                  carry_o,       // Carry
   input wire logic                  zero_o,        // Zero
   input wire logic                  sleep_o        // Sleeping
);
   logic       pend_reg;  // Page offset waiting
   logic [7:0] pbyte_reg; // Page offset byte
   logic       take;      // Instruction taken

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   assign take = instr_valid_i && instr_ready_o;

   // Track the page offset until the next taken instruction
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_reg <= 1'b0;
         pbyte_reg <= 8'h00;
      end else if (page_load_i) begin
         pend_reg <= 1'b1;
         pbyte_reg <= page_byte_i;
      end else if (take) begin
         pend_reg <= 1'b0;
      end
   end

   property p_shl_mem;
      take && opcode_i[12:2] == nsx_pkg::OP_SHL_MEM[12:2] && !opcode_i[0]
         |-> mem_req_o.wr && mem_req_o.wdata == {mem_rdata_i[2:0], 1'b0} ##1 carry_o == $past(mem_rdata_i[3]);
   endproperty
   a_shl_mem: assert property (p_shl_mem) else $error("memory left shift wrong");
   property p_shr_mem;
      take && opcode_i[12:2] == nsx_pkg::OP_SHR_MEM[12:2] && !opcode_i[0]
         |-> mem_req_o.wr && mem_req_o.wdata == {1'b0, mem_rdata_i[3:1]} ##1 carry_o == $past(mem_rdata_i[0]);
   endproperty
   a_shr_mem: assert property (p_shr_mem) else $error("memory right shift wrong");
   property p_two_cyc;
      take && (opcode_i[12:3] == nsx_pkg::OP_SHL_MEM[12:3] && opcode_i[0] || opcode_i[12:3] == nsx_pkg::OP_SUB_MR[12:3])
         |=> !instr_ready_o ##1 instr_ready_o;
   endproperty
   a_two_cyc: assert property (p_two_cyc) else $error("two-cycle timing wrong");
   property p_one_cyc;
      take && (opcode_i[12:3] == nsx_pkg::OP_SUB_RR[12:3] || opcode_i[12:3] == nsx_pkg::OP_SUB_RM[12:3])
         |=> instr_ready_o;
   endproperty
   a_one_cyc: assert property (p_one_cyc) else $error("one-cycle op stalled");
   property p_sub_imm;
      take && opcode_i[12:4] == nsx_pkg::OP_SUB_RI[12:4] |=> work_reg_1_o == $past(work_reg_1_o) - $past(opcode_i[3:0])
         && carry_o == ($past(work_reg_1_o) < $past(opcode_i[3:0]));
   endproperty
   a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong");
   property p_inc_flags;
      take && opcode_i == 13'h1861 |=> pointer_1_o == $past(pointer_1_o) + 16'h0001 && zero_o == (work_reg_1_o == 4'h0);
   endproperty
   a_inc_flags: assert property (p_inc_flags) else $error("post-increment flags wrong");
   property p_page;
      take && pend_reg && opcode_i[12:2] == nsx_pkg::OP_SHL_MEM[12:2] && !opcode_i[0]
         |-> mem_req_o.addr == {opcode_i[1] ? nsx_pkg::PAGE_BASE_2[15:8] : nsx_pkg::PAGE_BASE_1[15:8], pbyte_reg};
   endproperty
   a_page: assert property (p_page) else $error("page address wrong");
   property p_page_ign;
      take && pend_reg && opcode_i == 13'h10E1 |-> mem_req_o.addr == pointer_1_o;
   endproperty
   a_page_ign: assert property (p_page_ign) else $error("page offset not ignored");
   property p_sleep;
      (take && opcode_i == nsx_pkg::OP_SLEEP) ##1 !ext_irq_i |=> $rose(sleep_o);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");
   property p_wake;
      sleep_o && ext_irq_i |=> !sleep_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on interrupt");

   c_sleep: cover property (take && opcode_i == nsx_pkg::OP_SLEEP);
   c_page: cover property (take && pend_reg);
   c_mr_inc: cover property (take && opcode_i[12:3] == nsx_pkg::OP_SUB_MR[12:3] && opcode_i[0]);
endmodule

bind nsx_exec nsx_exec_monitor u_mon (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .opcode_i(opcode_i),
   .page_load_i(page_load_i), .page_byte_i(page_byte_i), .ext_irq_i(ext_irq_i), .mem_rdata_i(mem_rdata_i),
   .instr_ready_o(instr_ready_o), .mem_req_o(mem_req_o), .work_reg_1_o(work_reg_1_o),
   .pointer_1_o(pointer_1_o), .carry_o(carry_o), .zero_o(zero_o), .sleep_o(sleep_o)
);

// [bench/nibble_shift_subtract_exec_bench.sv]
`timescale 1ns/1ps
// Self-checking bench for the shift and subtract executor
module nibble_shift_subtract_exec_bench;
   logic                  clk = 1'b0;     // Core clock
   logic                  rst_n = 1'b0;   // Reset, active low
   logic                  valid = 1'b0;   // Opcode present
   logic [12:0]           opc = 13'h0000; // Opcode word
   logic                  pg_ld = 1'b0;   // Page load pulse
   logic [7:0]            pg_b = 8'h00;   // Page byte
   logic                  irq = 1'b0;     // Interrupt
   logic [3:0]            rdata;          // Read data
   logic                  ready;          // Ready
   nsx_pkg::nsx_mem_req_t req;            // Memory request
   logic [3:0]            r1, r2;         // Registers
   logic [15:0]           p1, p2;         // Pointers
   logic                  cy, zf, enter_sleep_op;    // Flags and sleep
   logic [3:0]            er [2];         // Expected registers
   logic [15:0]           ep [2];         // Expected pointers
   logic                  ec, ez, pend;   // Expected flags, page pending
   logic [7:0]            pb;             // Expected page byte
   logic [15:0]           ea;             // Last memory address
   logic [3:0]            sm [0:65535];   // Expected memory
   logic [12:0]           o;              // Random opcode
   int                    failures = 0;
   int                    n_checks = 0;

   nsx_exec uut (.ref_clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(valid), .opcode_i(opc), .page_load_i(pg_ld),
      .page_byte_i(pg_b), .ext_irq_i(irq), .mem_rdata_i(rdata), .instr_ready_o(ready), .mem_req_o(req),
      .work_reg_1_o(r1), .work_reg_2_o(r2), .pointer_1_o(p1), .pointer_2_o(p2), .carry_o(cy), .zero_o(zf),
      .sleep_o(enter_sleep_op));
   nsx_mem_model mem (.ref_clk_i(clk), .mem_req_i(req), .mem_rdata_o(rdata));

   // Clock generator
   always #12.5 clk = ~clk;

   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input bit ok, input string s);
      n_checks++;
      if (!ok) begin
         failures++;
         $display("BAD %0t %s", $time, s);
      end
   endtask

   task automatic cmp();
      chk({r1, r2, p1, p2, cy, zf} === {er[0], er[1], ep[0], ep[1], ec, ez} && mem.mem[ea] === sm[ea], "state");
   endtask

   task automatic clear_model();
      er = '{4'h0, 4'h0};
      ep = '{16'h0000, 16'h0000};
      ec = 1'b0;
      ez = 1'b0;
      pend = 1'b0;
   endtask

   // Expected effect of one taken opcode
   task automatic model(input logic [12:0] op);
      logic [15:0] a;
      logic [4:0]  d;
      logic [3:0]  m;
      logic        k, inc, wm, wr, mi, sh, r, rm;
      sh = op[12:3] == nsx_pkg::OP_SHL_MEM[12:3];
      mi = op[12:6] == nsx_pkg::OP_SUB_MI[12:6];
      rm = op[12:3] == nsx_pkg::OP_SUB_RM[12:3];
      k = mi ? op[5] : op[1];
      inc = mi ? op[4] : op[0];
      r = op[2];
      a = (pend && !inc) ? {k ? nsx_pkg::PAGE_BASE_2[15:8] : nsx_pkg::PAGE_BASE_1[15:8], pb} : ep[k];
      m = sm[a];
      wm = sh || mi || op[12:3] == nsx_pkg::OP_SUB_MR[12:3];
      wr = rm;
      d = 5'h00;
      if (sh) d = op[2] ? {m[0], 1'b0, m[3:1]} : {m, 1'b0};
      else if (mi) d = {1'b0, m} - {1'b0, op[3:0]};
      else if (wm) d = {1'b0, m} - {1'b0, er[r]};
      else if (wr) d = {1'b0, er[r]} - {1'b0, m};
      else if (op[12:3] == nsx_pkg::OP_SUB_RR[12:3]) begin
         wr = 1'b1;
         d = {1'b0, er[r]} - {1'b0, er[op[1]]};
      end else if (op[12:5] == nsx_pkg::OP_SUB_RI[12:5]) begin
         wr = 1'b1;
         r = op[4];
         d = {1'b0, er[r]} - {1'b0, op[3:0]};
      end else if (op == nsx_pkg::OP_SHR_REG_1 || op == nsx_pkg::OP_SHR_REG_2) begin
         wr = 1'b1;
         d = {er[r][0], 1'b0, er[r][3:1]};
      end
      if (wr || wm) ec = d[4];
      if (wr || wm) ez = d[3:0] == 4'h0;
      if (wr) er[r] = d[3:0];
      if (wm) sm[a] = d[3:0];
      if (wm || rm) ea = a;
      if ((wm || rm) && inc) ep[k] = ep[k] + 16'h0001;
      pend = 1'b0;
   endtask

   // Issue one opcode at a falling edge and wait for ready
   task automatic run(input logic [12:0] op);
      int n;
      n = 0;
      valid = 1'b1;
      opc = op;
      @(negedge clk);
      while (ready !== 1'b1 && n < 9) begin
         @(negedge clk);
         n++;
      end
      if (n >= 9) begin
         failures++;
         print_verdict();
      end
      model(op);
      cmp();
   endtask

   task automatic page(input logic [7:0] b);
      valid = 1'b0;
      pg_ld = 1'b1;
      pg_b = b;
      pend = 1'b1;
      pb = b;
      @(negedge clk);
      pg_ld = 1'b0;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h64f8));
      for (int i = 0; i < 65536; i++) begin
         if (i < 512 || i >= 65280) begin
            sm[i] = 4'($urandom);
            mem.mem[i] = sm[i];
         end
      end
      clear_model();
      ea = 16'h0000;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      cmp();
      for (int i = 0; i < 64; i++) run(13'h1840 + 13'(i));
      for (int i = 0; i < 8; i++) run(13'h10E0 + 13'(i));
      run(nsx_pkg::OP_SHR_REG_1);
      run(nsx_pkg::OP_SHR_REG_2);
      for (int i = 0; i < 64; i += 5) run(13'h1800 + 13'(i));
      $display("test directed done");
      for (int i = 0; i < 24; i++) begin
         page(8'($urandom));
         run((i < 8) ? 13'h10E0 + 13'(i) : 13'h1858 + 13'(i));
      end
      page(8'hFF);
      run(13'h182F);
      page(8'h00);
      run(13'h1810);
      $display("test page done");
      for (int i = 0; i < 300; i++) begin
         if ($urandom_range(0, 3) == 0) page(8'($urandom));
         case ($urandom_range(0, 2))
            0: o = 13'h10E0 + 13'($urandom_range(0, 7));
            1: o = 13'h10F1 | (13'($urandom_range(0, 1)) << 2);
            default: o = 13'h1800 + 13'($urandom_range(0, 127));
         endcase
         run(o);
      end
      $display("test random done");
      valid = 1'b1;
      opc = nsx_pkg::OP_SLEEP;
      @(negedge clk);
      valid = 1'b0;
      @(negedge clk);
      chk(enter_sleep_op === 1'b1, "no sleep");
      repeat (3) @(negedge clk);
      irq = 1'b1;
      @(negedge clk);
      irq = 1'b0;
      chk(enter_sleep_op === 1'b0, "no wake");
      model(nsx_pkg::OP_SLEEP);
      cmp();
      run(13'h1855);
      $display("test sleep done");
      valid = 1'b0;
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      clear_model();
      cmp();
      rst_n = 1'b1;
      run(13'h1801);
      $display("test reset done");
      print_verdict();
   end

   // Watchdog against a hang
   initial begin
      #2000000;
      failures++;
      print_verdict();
   end
endmodule
